// ===== mem_model.sv
// Byte memory standing behind the execution unit's bus, big-endian lanes.
// Assumes each request is held until mem_ack; lat adds wait cycles.
module mem_model
  import xfer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire size_t mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [1:0] wait_cnt;
  int n;
  logic [31:0] v;

  // One access per ack pulse; read lines flip while not answering
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_cnt == lat) begin
      n = (mem_size == size_byte) ? 1 : (mem_size == size_word) ? 2 : 4;
      v = 32'h0;
      for (int i = 0; i < n; i++) begin
        if (mem_we) mem[8'(mem_addr + i)] = mem_wdata[8*(n-1-i) +: 8];
        v = {v[23:0], mem[8'(mem_addr + i)]};
      end
      mem_ack <= 1'b1;
      mem_rdata <= v;
      wait_cnt <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking bench for the transfer execution unit.
// Assumes the memory model file and the design package are compiled first.
module tb_top
  import xfer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_src_mem = 1'b0;
  logic cmd_dst_mem = 1'b0;
  logic cmd_use_imm = 1'b0;
  op_t cmd_op = transfer_data;
  size_t cmd_size = size_long;
  logic [3:0] cmd_rs = 4'h0;
  logic [3:0] cmd_rd = 4'h0;
  logic [2:0] cmd_list_len = 3'h2;
  logic [31:0] cmd_imm = 32'h0;
  logic [31:0] cmd_addr = 32'h0;
  logic [31:0] cmd_target = 32'h0;
  logic [2:0] dbg_sel = 3'h0;
  logic [1:0] lat = 2'h0;
  logic cmd_ready, done, fault, branch_valid, mem_req, mem_we, mem_ack;
  size_t mem_size;
  logic [31:0] branch_addr, mem_addr, mem_wdata, mem_rdata, dbg_data;
  logic flt, brn;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int reqs = 0;

  xfer_exec DUT (.core_clk, .rst_b, .cmd_valid, .cmd_op, .cmd_size,
    .cmd_src_mem, .cmd_dst_mem, .cmd_use_imm, .cmd_rs, .cmd_rd,
    .cmd_list_len, .cmd_imm, .cmd_addr, .cmd_target, .dbg_sel, .cmd_ready,
    .done, .fault, .branch_valid, .branch_addr, .mem_req, .mem_we,
    .mem_size, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .dbg_data);
  mem_model mem_i (.core_clk, .rst_b, .lat, .mem_req, .mem_we, .mem_size,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  // Clock and hang guard
  always #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    cycles++;
    if (mem_req) reqs++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // Verdict and end of run
  task automatic stop_test();
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare and report
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issue one command, wait for done under a bound
  task automatic go(op_t op, size_t sz, logic [3:0] rs, rd,
      logic [31:0] imm, addr = 0, tgt = 0, logic [2:0] f = 0,
      logic [2:0] len = 2);
    int n;
    n = 0;
    @(posedge core_clk);
    {cmd_op, cmd_size, cmd_rs, cmd_rd, cmd_imm} <= {op, sz, rs, rd, imm};
    {cmd_addr, cmd_target, cmd_list_len} <= {addr, tgt, len};
    {cmd_src_mem, cmd_dst_mem, cmd_use_imm} <= f;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    // Fault ops answer right after the take edge, so look there first
    while (done !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    flt = fault;
    brn = branch_valid;
    if (n >= 300) begin
      fails++;
      $display("ERROR done expected 1 seen 0");
    end
  endtask

  // Register preset, register readback, memory word readback
  task automatic setr(logic [3:0] r, logic [31:0] v);
    go(transfer_data, size_long, 4'h0, r, v, 0, 0, 3'h1);
  endtask
  task automatic cr(string what, logic [2:0] r, logic [31:0] exp);
    @(posedge core_clk);
    dbg_sel <= r;
    repeat (2) @(posedge core_clk);
    #1;
    chk(what, exp, dbg_data);
  endtask
  function automatic logic [31:0] mword(int a);
    return {mem_i.mem[a], mem_i.mem[a+1], mem_i.mem[a+2], mem_i.mem[a+3]};
  endfunction

  // Sized moves into register parts and memory
  task automatic t_move();
    setr(4'h1, 32'h1122_3344);
    go(transfer_data, size_byte, 4'h0, 4'h9, 32'hab, 0, 0, 3'h1);
    go(transfer_data, size_word, 4'h0, 4'h9, 32'h5566, 0, 0, 3'h1);
    go(transfer_data, size_byte, 4'h0, 4'h1, 32'hcd, 0, 0, 3'h1);
    cr("er1 parts", 3'h1, 32'h5566_cdab);
    go(transfer_data, size_long, 4'h1, 4'h0, 0, 0, 32'h40, 3'h2);
    chk("mem long", 32'h5566_cdab, mword(32'h40));
    go(transfer_data, size_word, 4'h0, 4'h2, 0, 32'h42, 0, 3'h4);
    cr("r2 from mem", 3'h2, 32'h0000_cdab);
  endtask

  // Single push and pop with a slow memory
  task automatic t_stack();
    lat <= 2'h1;
    setr(4'h7, 32'h80);
    go(stack_save, size_long, 4'h1, 4'h0, 0);
    cr("sp push", 3'h7, 32'h7c);
    chk("pushed", 32'h5566_cdab, mword(32'h7c));
    go(stack_restore, size_word, 4'h0, 4'h3, 0);
    cr("r3 pop", 3'h3, 32'h5566);
    cr("sp pop", 3'h7, 32'h7e);
  endtask

  // Zero-extended address compute from register and memory
  task automatic t_lea();
    go(effective_address_compute, size_byte, 4'h9, 4'h2, 32'h100);
    cr("ea reg", 3'h2, 32'h1ab);
    go(effective_address_compute, size_word, 4'h0, 4'h3, 32'h10, 32'h42, 0,
      3'h4);
    cr("ea mem", 3'h3, 32'hcdbb);
  endtask

  // Multiple save then restore for list lengths two to four
  task automatic t_multi();
    lat <= 2'h2;
    for (int len = 2; len <= 4; len++) begin
      setr(4'h7, 32'h80);
      for (int r = 0; r < len; r++) setr(4'(r), 32'h0a00_0000 + r * 17);
      go(store_multiple_to_stack, size_long, 4'h0, 4'h0, 0, 0, 0, 0, 3'(len));
      cr("sp save", 3'h7, 32'h80 - 4 * len);
      for (int r = 0; r < len; r++) setr(4'(r), 32'h0);
      go(load_multiple_from_stack, size_long, 4'h0, 4'h0, 0, 0, 0, 0,
        3'(len));
      cr("sp restore", 3'h7, 32'h80);
      for (int r = 0; r < len; r++) begin
        cr("reg restore", 3'(r), 32'h0a00_0000 + r * 17);
      end
    end
  endtask

  // Unsupported peripheral transfers fault without bus traffic
  task automatic t_fault();
    int n;
    n = reqs;
    go(peripheral_read_sync, size_byte, 4'h1, 4'h2, 0);
    chk("read fault", 32'h1, flt);
    go(peripheral_write_sync, size_byte, 4'h1, 4'h2, 0);
    chk("write fault", 32'h1, flt);
    chk("fault bus", n, reqs);
  endtask

  // Each copy form but zero-stop, count three, then a zero count
  task automatic t_copy();
    op_t ops [5] = '{legacy_block_copy_byte_count,
      legacy_block_copy_word_count, block_copy_bytes, block_copy_words,
      block_copy_longwords};
    int es [5] = '{1, 1, 1, 2, 4};
    int n;
    for (int i = 0; i < 64; i++) mem_i.mem[i] = 8'(i + 1);
    for (int k = 0; k < 5; k++) begin
      lat <= 2'(k % 3);
      n = 3 * es[k];
      for (int j = 0; j < 16; j++) mem_i.mem[8'h80 + j] = 8'hee;
      setr(4'h5, 32'h0);
      setr(4'h6, 32'h80);
      setr(4'h4, (k == 0) ? 32'h0103 : 32'h3);
      go(ops[k], size_byte, 4'h0, 4'h0, 0);
      for (int j = 0; j < 16; j++) begin
        chk("copy data", (j < n) ? j + 1 : 8'hee, mem_i.mem[8'h80 + j]);
      end
      chk("no branch", 32'h0, brn);
      cr("src ptr", 3'h5, n);
      cr("dst ptr", 3'h6, 32'h80 + n);
      cr("count", 3'h4, (k == 0) ? 32'h0100 : 32'h0);
    end
    setr(4'h4, 32'h0);
    setr(4'h5, 32'h20);
    go(block_copy_bytes, size_byte, 4'h0, 4'h0, 0);
    cr("zero count", 3'h5, 32'h20);
  endtask

  // Zero byte ends the copy and branches
  task automatic t_zstop();
    for (int j = 0; j < 4; j++) mem_i.mem[8'h90 + j] = 8'hee;
    mem_i.mem[8'h12] = 8'h0;
    setr(4'h5, 32'h10);
    setr(4'h6, 32'h90);
    setr(4'h4, 32'h4);
    go(string_copy_zero_stop, size_byte, 4'h0, 4'h0, 0, 0, 32'h1234);
    chk("branch", 32'h1, brn);
    chk("target", 32'h1234, branch_addr);
    chk("zero written", 32'h0, mem_i.mem[8'h92]);
    chk("stopped", 32'hee, mem_i.mem[8'h93]);
    cr("zs count", 3'h4, 32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_move();
    t_stack();
    t_lea();
    t_multi();
    t_fault();
    t_copy();
    t_zstop();
    stop_test();
  end
endmodule

// ===== xfer_exec.sv
// Execution unit for data moves, stack save/restore and block copies.
// Assumes one decoded command at a time from the decoder and a memory
// bus that holds read data valid in the cycle mem_ack is high.
module xfer_exec
  import xfer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire op_t cmd_op,
  input wire size_t cmd_size,
  input wire logic cmd_src_mem,
  input wire logic cmd_dst_mem,
  input wire logic cmd_use_imm,
  input wire logic [3:0] cmd_rs,
  input wire logic [3:0] cmd_rd,
  input wire logic [2:0] cmd_list_len,
  input wire logic [31:0] cmd_imm,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_target,
  input wire logic [2:0] dbg_sel,
  output logic cmd_ready,
  output logic done,
  output logic fault,
  output logic branch_valid,
  output logic [31:0] branch_addr,
  output logic mem_req,
  output logic mem_we,
  output size_t mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] dbg_data
);

  typedef logic [REG_COUNT-1:0][31:0] rf_t;

  typedef struct packed {
    state_t st;
    op_t op;
    size_t sz;
    logic dst_mem;
    logic [3:0] rd;
    logic [2:0] left;
    logic [2:0] idx;
    logic [31:0] imm;
    logic [31:0] target;
    logic [31:0] tmp;
    rf_t rf;
    logic ready;
    logic done;
    logic fault;
    logic br_valid;
    logic [31:0] br_addr;
    logic req;
    logic we;
    size_t msz;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] dbg;
  } core_t;

  core_t s, next_s;

  // Bytes per element of a size
  function automatic logic [31:0] size_bytes(input size_t z);
    unique case (z)
      size_byte: size_bytes = 32'h0000_0001;
      size_word: size_bytes = 32'h0000_0002;
      default: size_bytes = LONG_BYTES;
    endcase
  endfunction

  // Keep only the low bytes of a value for its size
  function automatic logic [31:0] trunc(input size_t z, input logic [31:0] v);
    unique case (z)
      size_byte: trunc = {24'h000000, v[7:0]};
      size_word: trunc = {16'h0000, v[15:0]};
      default: trunc = v;
    endcase
  endfunction

  // Register view: bytes RnH (sel<8) / RnL, words Rn (sel<8) / En
  function automatic logic [31:0] rd_reg(input rf_t f, input size_t z,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = f[sel[2:0]];
    unique case (z)
      size_byte: rd_reg = sel[3] ? {24'h000000, r[7:0]} :
                                   {24'h000000, r[15:8]};
      size_word: rd_reg = sel[3] ? {16'h0000, r[31:16]} :
                                   {16'h0000, r[15:0]};
      default: rd_reg = r;
    endcase
  endfunction

  // Write one register view, other bits untouched
  function automatic rf_t wr_reg(input rf_t f, input size_t z,
                                 input logic [3:0] sel,
                                 input logic [31:0] v);
    rf_t g;
    g = f;
    unique case (z)
      size_byte: begin
        if (sel[3]) g[sel[2:0]][7:0] = v[7:0];
        else g[sel[2:0]][15:8] = v[7:0];
      end
      size_word: begin
        if (sel[3]) g[sel[2:0]][31:16] = v[15:0];
        else g[sel[2:0]][15:0] = v[15:0];
      end
      default: g[sel[2:0]] = v;
    endcase
    wr_reg = g;
  endfunction

  // Count register view depends on the copy form
  function automatic logic [3:0] cnt_sel(input op_t o);
    cnt_sel = (o == legacy_block_copy_byte_count) ? COUNT_BYTE_SEL :
                                                    COUNT_WORD_SEL;
  endfunction

  function automatic size_t cnt_size(input op_t o);
    cnt_size = (o == legacy_block_copy_byte_count) ? size_byte : size_word;
  endfunction

  logic [31:0] rdata;
  logic [31:0] count_now;
  logic [31:0] sp_now;
  assign rdata = trunc(s.msz, mem_rdata);
  assign count_now = rd_reg(s.rf, cnt_size(s.op), cnt_sel(s.op));
  assign sp_now = s.rf[SP_REG];

  // Sequencer: next state of the whole unit
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.fault = 1'b0;
    next_s.br_valid = 1'b0;
    next_s.dbg = s.rf[dbg_sel];
    unique case (s.st)
      st_idle: begin
        if (cmd_valid) begin
          next_s.ready = 1'b0;
          next_s.op = cmd_op;
          next_s.sz = cmd_size;
          next_s.dst_mem = cmd_dst_mem;
          next_s.rd = cmd_rd;
          next_s.imm = cmd_imm;
          next_s.target = cmd_target;
          next_s.msz = cmd_size;
          next_s.we = 1'b0;
          unique case (cmd_op)
            transfer_data, effective_address_compute: begin
              // Operand from memory, immediate (moves only) or register
              if (cmd_src_mem) begin
                next_s.st = st_read;
                next_s.req = 1'b1;
                next_s.addr = cmd_addr;
              end else begin
                next_s.tmp = cmd_use_imm ? trunc(cmd_size, cmd_imm) :
                             rd_reg(s.rf, cmd_size, cmd_rs);
                if (cmd_op == effective_address_compute) begin
                  next_s.tmp = rd_reg(s.rf, cmd_size, cmd_rs);
                end
                next_s.st = st_put;
              end
            end
            stack_restore: begin
              next_s.st = st_read;
              next_s.req = 1'b1;
              next_s.addr = sp_now;
            end
            stack_save: begin
              next_s.rf[SP_REG] = sp_now - size_bytes(cmd_size);
              next_s.st = st_write;
              next_s.req = 1'b1;
              next_s.we = 1'b1;
              next_s.addr = sp_now - size_bytes(cmd_size);
              next_s.wdata = rd_reg(s.rf, cmd_size, cmd_rs);
            end
            load_multiple_from_stack: begin
              // Highest register pops first
              next_s.msz = size_long;
              next_s.left = cmd_list_len;
              next_s.idx = cmd_rd[2:0] + cmd_list_len - 3'h1;
              next_s.st = st_read;
              next_s.req = 1'b1;
              next_s.addr = sp_now;
            end
            store_multiple_to_stack: begin
              // Lowest register pushed first
              next_s.msz = size_long;
              next_s.left = cmd_list_len;
              next_s.idx = cmd_rs[2:0];
              next_s.rf[SP_REG] = sp_now - LONG_BYTES;
              next_s.st = st_write;
              next_s.req = 1'b1;
              next_s.we = 1'b1;
              next_s.addr = sp_now - LONG_BYTES;
              next_s.wdata = s.rf[cmd_rs[2:0]];
            end
            peripheral_read_sync, peripheral_write_sync: begin
              // Not supported: report and stay idle
              next_s.fault = 1'b1;
              next_s.done = 1'b1;
              next_s.ready = 1'b1;
            end
            block_copy_words: begin
              next_s.msz = size_word;
              next_s.st = st_copy;
            end
            block_copy_longwords: begin
              next_s.msz = size_long;
              next_s.st = st_copy;
            end
            default: begin
              // Byte copies: legacy forms, sized byte, zero-stop
              next_s.msz = size_byte;
              next_s.st = st_copy;
            end
          endcase
        end
      end
      st_read: begin
        if (mem_ack) begin
          next_s.req = 1'b0;
          unique case (s.op)
            stack_restore: begin
              next_s.rf = wr_reg(s.rf, s.sz, s.rd, rdata);
              next_s.rf[SP_REG] = sp_now + size_bytes(s.sz);
              next_s.st = st_idle;
            end
            load_multiple_from_stack: begin
              next_s.rf[s.idx] = rdata;
              next_s.rf[SP_REG] = sp_now + LONG_BYTES;
              next_s.left = s.left - 3'h1;
              next_s.idx = s.idx - 3'h1;
              if (s.left != 3'h1) begin
                next_s.req = 1'b1;
                next_s.addr = sp_now + LONG_BYTES;
              end else begin
                next_s.st = st_idle;
              end
            end
            transfer_data, effective_address_compute: begin
              next_s.tmp = rdata;
              next_s.st = st_put;
            end
            default: begin
              // Block element read, now store it
              next_s.tmp = rdata;
              next_s.st = st_write;
              next_s.req = 1'b1;
              next_s.we = 1'b1;
              next_s.addr = s.rf[DST_PTR_REG];
              next_s.wdata = rdata;
            end
          endcase
        end
      end
      st_write: begin
        if (mem_ack) begin
          next_s.req = 1'b0;
          next_s.we = 1'b0;
          unique case (s.op)
            store_multiple_to_stack: begin
              next_s.left = s.left - 3'h1;
              next_s.idx = s.idx + 3'h1;
              if (s.left != 3'h1) begin
                next_s.rf[SP_REG] = sp_now - LONG_BYTES;
                next_s.req = 1'b1;
                next_s.we = 1'b1;
                next_s.addr = sp_now - LONG_BYTES;
                next_s.wdata = s.rf[s.idx + 3'h1];
              end else begin
                next_s.st = st_idle;
              end
            end
            transfer_data, stack_save: next_s.st = st_idle;
            default: begin
              // Advance pointers, count down
              next_s.rf[SRC_PTR_REG] = s.rf[SRC_PTR_REG] +
                                       size_bytes(s.msz);
              next_s.rf[DST_PTR_REG] = s.rf[DST_PTR_REG] +
                                       size_bytes(s.msz);
              next_s.rf = wr_reg(next_s.rf, cnt_size(s.op), cnt_sel(s.op),
                                 count_now - 32'h0000_0001);
              next_s.st = st_copy;
              if (s.op == string_copy_zero_stop && s.tmp[7:0] == 8'h00) begin
                next_s.br_valid = 1'b1;
                next_s.br_addr = s.target;
                next_s.st = st_idle;
              end
            end
          endcase
        end
      end
      st_put: begin
        // Destination stage of a move or address compute
        if (s.op == effective_address_compute) begin
          next_s.rf = wr_reg(s.rf, size_long, s.rd, s.tmp + s.imm);
          next_s.st = st_idle;
        end else if (s.dst_mem) begin
          next_s.st = st_write;
          next_s.req = 1'b1;
          next_s.we = 1'b1;
          next_s.msz = s.sz;
          next_s.addr = s.target;
          next_s.wdata = s.tmp;
        end else begin
          next_s.rf = wr_reg(s.rf, s.sz, s.rd, s.tmp);
          next_s.st = st_idle;
        end
      end
      st_copy: begin
        // Zero count ends the copy before any access
        if (count_now == 32'h0000_0000) begin
          next_s.st = st_idle;
        end else begin
          next_s.st = st_read;
          next_s.req = 1'b1;
          next_s.we = 1'b0;
          next_s.addr = s.rf[SRC_PTR_REG];
        end
      end
    endcase
    // Completion pulse on return to idle
    if (s.st != st_idle && next_s.st == st_idle) begin
      next_s.done = 1'b1;
      next_s.ready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= st_idle;
      s.rf <= {REG_COUNT{REG_RESET}};
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_ready = s.ready;
  assign done = s.done;
  assign fault = s.fault;
  assign branch_valid = s.br_valid;
  assign branch_addr = s.br_addr;
  assign mem_req = s.req;
  assign mem_we = s.we;
  assign mem_size = s.msz;
  assign mem_addr = s.addr;
  assign mem_wdata = s.wdata;
  assign dbg_data = s.dbg;

  // Checks
  AST_MOVE_REG: assert property (@(posedge core_clk) disable iff (!rst_b)
    s.st == st_put && s.op == transfer_data && !s.dst_mem && s.sz == size_long
    |=> s.rf[$past(s.rd[2:0])] == $past(s.tmp) && done)
    else $error("move to register lost");
  AST_POP_ADDR: assert property (@(posedge core_clk) disable iff (!rst_b)
    s.st == st_read && s.op == stack_restore && mem_ack
    |=> sp_now == $past(mem_addr) + size_bytes($past(s.sz)))
    else $error("restore did not post-increment");
  AST_PUSH_PREDEC: assert property (@(posedge core_clk) disable iff (!rst_b)
    s.st == st_write && s.op == stack_save |-> mem_addr == sp_now && mem_we)
    else $error("save not at decremented SP");
  AST_MULTI_LOAD_LONG: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    mem_req && s.op == load_multiple_from_stack |-> mem_size == size_long)
    else $error("multiple restore not longword");
  AST_MULTI_STORE_ADDR: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    mem_req && s.op == store_multiple_to_stack
    |-> mem_size == size_long && mem_we && mem_addr == sp_now)
    else $error("multiple save address wrong");
  AST_ADDR_COMPUTE: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    s.st == st_put && s.op == effective_address_compute
    |=> s.rf[$past(s.rd[2:0])] == $past(s.tmp) + $past(s.imm))
    else $error("address compute wrong");
  AST_UNSUPPORTED: assert property (@(posedge core_clk) disable iff (!rst_b)
    cmd_ready && cmd_valid &&
    (cmd_op == peripheral_read_sync || cmd_op == peripheral_write_sync)
    |=> fault && done && !mem_req ##1 cmd_ready)
    else $error("peripheral transfer not rejected");
  AST_COPY_ADV: assert property (@(posedge core_clk) disable iff (!rst_b)
    s.st == st_write && s.op >= legacy_block_copy_byte_count && mem_ack
    |=> s.rf[SRC_PTR_REG] == $past(s.rf[SRC_PTR_REG]) + size_bytes(s.msz))
    else $error("source pointer not advanced");
  AST_ZERO_COUNT: assert property (@(posedge core_clk) disable iff (!rst_b)
    s.st == st_copy && count_now == 32'h0000_0000 |=> done && !mem_req)
    else $error("zero count still copied");
  AST_ZERO_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
    s.st == st_write && s.op == string_copy_zero_stop && mem_ack &&
    mem_wdata[7:0] == 8'h00 |=> branch_valid && branch_addr == s.target)
    else $error("zero byte did not branch");
  COV_COPY: cover property (@(posedge core_clk) disable iff (!rst_b)
    s.op == block_copy_longwords && s.st == st_copy ##1 mem_req);
  COV_STOP: cover property (@(posedge core_clk) disable iff (!rst_b)
    branch_valid);
  COV_MULTI_STORE: cover property (@(posedge core_clk) disable iff (!rst_b)
    s.op == store_multiple_to_stack && done);

endmodule

// ===== xfer_pkg.sv
// Constants and types for the data and block transfer execution unit.
// Assumes a byte-addressed memory bus with right-aligned data lanes.
package xfer_pkg;

  // Operation codes handed over by the instruction decoder
  typedef enum logic [3:0] {
    transfer_data,
    stack_restore,
    stack_save,
    load_multiple_from_stack,
    store_multiple_to_stack,
    effective_address_compute,
    peripheral_read_sync,
    peripheral_write_sync,
    legacy_block_copy_byte_count,
    legacy_block_copy_word_count,
    block_copy_bytes,
    block_copy_words,
    block_copy_longwords,
    string_copy_zero_stop
  } op_t;

  // Operand sizes
  typedef enum logic [1:0] {
    size_byte,
    size_word,
    size_long
  } size_t;

  // Sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_write,
    st_put,
    st_copy
  } state_t;

  localparam int REG_COUNT = 8;
  localparam logic [2:0] SP_REG = 3'h7;
  localparam logic [2:0] SRC_PTR_REG = 3'h5;
  localparam logic [2:0] DST_PTR_REG = 3'h6;
  // Count register: R4 as a word, R4L as a byte
  localparam logic [3:0] COUNT_WORD_SEL = 4'h4;
  localparam logic [3:0] COUNT_BYTE_SEL = 4'hc;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] LONG_BYTES = 32'h0000_0004;

endpackage
